// ### mcrb_bank.sv
// module: axi4-lite calibration register bank with detector latches
//
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/10ps

// ***************************************************************************
// register bank top
// ***************************************************************************

// Function
// - channel 3 negative detector code lives in threshold register bits 15:8
// - channel 3 positive detector code lives in threshold register bits 7:0
// - 8-bit detector codes pass unchanged; zero lowest, all-ones highest
// - three 16-bit signed current offsets, one per phase, feed the decimator
// - three 16-bit signed voltage offsets, one per phase, feed the decimator
// - phase B voltage temperature gain is the high byte of the AB register
// - phase C gain is the low byte; high byte reserved, reads zero
// - frequency phase term is the low byte; high byte reserved
// - all registers read and write; reset clears them to zero
// - any detection write loads all detector latches; latches ignore reset
module mcrb_bank (
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  input  wire logic [mcrb_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]                  s_axi_awprot,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [mcrb_pkg::DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  input  wire logic [mcrb_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]                  s_axi_arprot,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic [mcrb_pkg::DATA_W-1:0]      s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  input  wire logic                        other_detect_wr,
  output mcrb_pkg::mcrb_detect_s           chan3_detect,
  output mcrb_pkg::mcrb_cal_s              cal
);

  // *************************************************************************
  // decode helpers
  // *************************************************************************

  // word index of a byte address; low two bits are ignored
  function automatic logic [5:0] word_of(
    input logic [mcrb_pkg::ADDR_W-1:0] addr
  );
    word_of = addr[mcrb_pkg::ADDR_W-1:mcrb_pkg::WORD_LSB];
  endfunction

  function automatic logic addr_hit(
    input logic [mcrb_pkg::ADDR_W-1:0] addr
  );
    logic [5:0] w;
    w        = word_of(addr);
    addr_hit = (w >= mcrb_pkg::IDX_FIRST) && (w <= mcrb_pkg::IDX_LAST);
  endfunction

  // slot in the storage array; only meaningful when addr_hit is true
  function automatic logic [3:0] slot_of(
    input logic [mcrb_pkg::ADDR_W-1:0] addr
  );
    logic [5:0] d;
    d       = word_of(addr) - mcrb_pkg::IDX_FIRST;
    slot_of = d[3:0];
  endfunction

  // storage slot of a register index from the map
  function automatic logic [3:0] slot_index(
    input logic [5:0] idx
  );
    logic [5:0] d;
    d          = idx - mcrb_pkg::IDX_FIRST;
    slot_index = d[3:0];
  endfunction

  // writable bits; reserved high bytes never store anything
  function automatic logic [15:0] mask_of(input logic [3:0] slot);
    logic [5:0] w;
    w = mcrb_pkg::IDX_FIRST + {2'h0, slot};
    if (w == mcrb_pkg::IDX_VOLT_TEMP_GAIN_C) begin
      mask_of = mcrb_pkg::MASK_LOW;
    end else if (w == mcrb_pkg::IDX_FREQUENCY_PHASE_COMP) begin
      mask_of = mcrb_pkg::MASK_LOW;
    end else begin
      mask_of = mcrb_pkg::MASK_FULL;
    end
  endfunction

  // merge bus data into the old value under byte strobes and field mask
  function automatic logic [15:0] merge(
    input logic [15:0] old_v,
    input logic [15:0] new_v,
    input logic [1:0]  strb,
    input logic [15:0] mask
  );
    logic [15:0] en;
    en    = {{mcrb_pkg::BYTE_W{strb[1]}}, {mcrb_pkg::BYTE_W{strb[0]}}} & mask;
    merge = (old_v & ~en) | (new_v & en);
  endfunction

  // *************************************************************************
  // storage
  // *************************************************************************

  logic [15:0]                 regs_q [mcrb_pkg::NUM_REGS];
  logic [mcrb_pkg::ADDR_W-1:0] aw_addr_q;
  logic                        aw_have_q;
  logic                        awready_q;
  logic [15:0]                 w_data_q;
  logic [1:0]                  w_strb_q;
  logic                        w_have_q;
  logic                        wready_q;
  logic                        bvalid_q;
  logic [1:0]                  bresp_q;
  logic                        arready_q;
  logic                        rvalid_q;
  logic [1:0]                  rresp_q;
  logic [mcrb_pkg::DATA_W-1:0] rdata_q;
  logic [7:0]                  neg_code_q;
  logic [7:0]                  pos_code_q;

  logic                        wr_fire;
  logic                        wr_hit;
  logic [3:0]                  wr_slot;
  logic [15:0]                 wr_value;
  logic                        thr_wr;
  logic [15:0]                 thr_next;
  logic                        detect_load;
  logic [15:0]                 thr_val;
  logic [15:0]                 cur_a_val;
  logic [15:0]                 cur_b_val;
  logic [15:0]                 cur_c_val;
  logic [15:0]                 volt_a_val;
  logic [15:0]                 volt_b_val;
  logic [15:0]                 volt_c_val;
  logic [15:0]                 gain_ab_val;
  logic [15:0]                 gain_c_val;
  logic [15:0]                 freq_comp_val;
  logic                        rd_take;
  logic                        rd_hit;
  logic [3:0]                  rd_slot;

  // *************************************************************************
  // write address and data capture
  // *************************************************************************

  // both channels are taken in either order; each stalls until the response
  // has been accepted, so only one write is ever in flight
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b1;
      aw_have_q <= 1'b0;
      aw_addr_q <= '0;
    end else if (s_axi_awvalid && awready_q) begin
      awready_q <= 1'b0;
      aw_have_q <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
    end else if (s_axi_bready && bvalid_q) begin
      awready_q <= 1'b1;
      aw_have_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready_q <= 1'b1;
      w_have_q <= 1'b0;
      w_data_q <= mcrb_pkg::REG_RESET;
      w_strb_q <= 2'h0;
    end else if (s_axi_wvalid && wready_q) begin
      wready_q <= 1'b0;
      w_have_q <= 1'b1;
      w_data_q <= s_axi_wdata[mcrb_pkg::REG_W-1:0];
      w_strb_q <= s_axi_wstrb[1:0];
    end else if (s_axi_bready && bvalid_q) begin
      wready_q <= 1'b1;
      w_have_q <= 1'b0;
    end
  end

  // *************************************************************************
  // write commit and response
  // *************************************************************************

  assign wr_fire  = aw_have_q && w_have_q && !bvalid_q;
  assign wr_hit   = addr_hit(aw_addr_q);
  assign wr_slot  = slot_of(aw_addr_q);
  assign wr_value = merge(regs_q[wr_slot], w_data_q, w_strb_q,
                          mask_of(wr_slot));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= mcrb_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_hit ? mcrb_pkg::RESP_OKAY : mcrb_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < mcrb_pkg::NUM_REGS; i++) begin
        regs_q[i] <= mcrb_pkg::REG_RESET;
      end
    end else if (wr_fire && wr_hit) begin
      regs_q[wr_slot] <= wr_value;
    end
  end

  // *************************************************************************
  // register views
  // *************************************************************************

  // each register looked up by its map index, so a reordered map cannot
  // silently route the wrong slot to the datapath
  assign thr_val       =
    regs_q[slot_index(mcrb_pkg::IDX_CHAN3_DETECT_THRESHOLD)];
  assign cur_a_val     =
    regs_q[slot_index(mcrb_pkg::IDX_PHASE_A_CURRENT_OFFSET)];
  assign cur_b_val     =
    regs_q[slot_index(mcrb_pkg::IDX_PHASE_B_CURRENT_OFFSET)];
  assign cur_c_val     =
    regs_q[slot_index(mcrb_pkg::IDX_PHASE_C_CURRENT_OFFSET)];
  assign volt_a_val    =
    regs_q[slot_index(mcrb_pkg::IDX_PHASE_A_VOLTAGE_OFFSET)];
  assign volt_b_val    =
    regs_q[slot_index(mcrb_pkg::IDX_PHASE_B_VOLTAGE_OFFSET)];
  assign volt_c_val    =
    regs_q[slot_index(mcrb_pkg::IDX_PHASE_C_VOLTAGE_OFFSET)];
  assign gain_ab_val   =
    regs_q[slot_index(mcrb_pkg::IDX_VOLT_TEMP_GAIN_AB)];
  assign gain_c_val    =
    regs_q[slot_index(mcrb_pkg::IDX_VOLT_TEMP_GAIN_C)];
  assign freq_comp_val =
    regs_q[slot_index(mcrb_pkg::IDX_FREQUENCY_PHASE_COMP)];

  // *************************************************************************
  // detector configuration latches
  // *************************************************************************

  // held off during reset so an aborted write never reaches the latches
  assign thr_wr   = aresetn && wr_fire && wr_hit &&
    (wr_slot == slot_index(mcrb_pkg::IDX_CHAN3_DETECT_THRESHOLD));
  assign thr_next = thr_wr ? wr_value : thr_val;

  // a write to this bank's threshold register or to a sibling detection
  // register loads the latches with the value the register is about to hold
  assign detect_load = thr_wr || other_detect_wr;

  // deliberately outside the reset: contents survive digital resets and
  // are undefined until the first detection write after power-up
  always_ff @(posedge aclk) begin
    if (detect_load) begin
      neg_code_q <=
        thr_next[mcrb_pkg::HI_MSB:mcrb_pkg::HI_LSB];
      pos_code_q <= thr_next[mcrb_pkg::LO_MSB:0];
    end
  end

  // *************************************************************************
  // read channel
  // *************************************************************************

  assign rd_take = s_axi_arvalid && arready_q;
  assign rd_hit  = addr_hit(s_axi_araddr);
  assign rd_slot = slot_of(s_axi_araddr);

  // one read at a time; data answers one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
    end else if (rd_take) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
    end else if (s_axi_rready && rvalid_q) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
    end
  end

  // data and response are captured as the address is taken and then held
  // unchanged until the master accepts them
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rresp_q <= mcrb_pkg::RESP_OKAY;
      rdata_q <= '0;
    end else if (rd_take && rd_hit) begin
      rresp_q <= mcrb_pkg::RESP_OKAY;
      rdata_q <= {{(mcrb_pkg::DATA_W - mcrb_pkg::REG_W){1'b0}},
                  regs_q[rd_slot]};
    end else if (rd_take) begin
      rresp_q <= mcrb_pkg::RESP_SLVERR;
      rdata_q <= '0;
    end
  end

  // *************************************************************************
  // outputs
  // *************************************************************************

  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rresp   = rresp_q;
  assign s_axi_rdata   = rdata_q;

  // codes go to the threshold dac untouched; the dac scales them linearly
  assign chan3_detect.negative_detector_code = neg_code_q;
  assign chan3_detect.positive_detector_code = pos_code_q;

  // offsets are two's complement; the decimator treats them as signed
  assign cal.phase_a_current_offset = cur_a_val;
  assign cal.phase_b_current_offset = cur_b_val;
  assign cal.phase_c_current_offset = cur_c_val;
  assign cal.phase_a_voltage_offset = volt_a_val;
  assign cal.phase_b_voltage_offset = volt_b_val;
  assign cal.phase_c_voltage_offset = volt_c_val;

  assign cal.phase_b_volt_temp_gain =
    gain_ab_val[mcrb_pkg::HI_MSB:mcrb_pkg::HI_LSB];
  assign cal.phase_a_volt_temp_gain =
    gain_ab_val[mcrb_pkg::LO_MSB:0];
  assign cal.phase_c_volt_temp_gain =
    gain_c_val[mcrb_pkg::LO_MSB:0];
  assign cal.freq_phase_term =
    freq_comp_val[mcrb_pkg::LO_MSB:0];

endmodule

// ### mcrb_pkg.sv
// package: register map, field layout and bus constants of the calibration bank
package mcrb_pkg;

  // ***********************************************************************
  // register index map (byte address is four times the index)
  // ***********************************************************************
  localparam logic [5:0] IDX_CHAN3_DETECT_THRESHOLD = 6'h13;
  localparam logic [5:0] IDX_PHASE_A_CURRENT_OFFSET = 6'h14;
  localparam logic [5:0] IDX_PHASE_B_CURRENT_OFFSET = 6'h15;
  localparam logic [5:0] IDX_PHASE_C_CURRENT_OFFSET = 6'h16;
  localparam logic [5:0] IDX_PHASE_A_VOLTAGE_OFFSET = 6'h17;
  localparam logic [5:0] IDX_PHASE_B_VOLTAGE_OFFSET = 6'h18;
  localparam logic [5:0] IDX_PHASE_C_VOLTAGE_OFFSET = 6'h19;
  localparam logic [5:0] IDX_VOLT_TEMP_GAIN_AB      = 6'h1A;
  localparam logic [5:0] IDX_VOLT_TEMP_GAIN_C       = 6'h1B;
  localparam logic [5:0] IDX_FREQUENCY_PHASE_COMP   = 6'h1C;

  localparam logic [5:0] IDX_FIRST = IDX_CHAN3_DETECT_THRESHOLD;
  localparam logic [5:0] IDX_LAST  = IDX_FREQUENCY_PHASE_COMP;
  localparam int         NUM_REGS  = 10;

  // ***********************************************************************
  // widths, field positions, reset values
  // ***********************************************************************
  localparam int         ADDR_W     = 8;
  localparam int         DATA_W     = 32;
  localparam int         REG_W      = 16;
  localparam int         BYTE_W     = 8;
  localparam int         WORD_LSB   = 2;
  localparam int         HI_LSB     = 8;
  localparam int         LO_MSB     = 7;
  localparam int         HI_MSB     = 15;
  localparam logic [15:0] REG_RESET  = 16'h0000;
  localparam logic [15:0] MASK_FULL  = 16'hFFFF;
  localparam logic [15:0] MASK_LOW   = 16'h00FF;

  // ***********************************************************************
  // axi4-lite response codes
  // ***********************************************************************
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ***********************************************************************
  // carriers toward the metering datapath
  // ***********************************************************************
  typedef struct packed {
    logic [7:0] negative_detector_code;
    logic [7:0] positive_detector_code;
  } mcrb_detect_s;

  typedef struct packed {
    logic [15:0] phase_a_current_offset;
    logic [15:0] phase_b_current_offset;
    logic [15:0] phase_c_current_offset;
    logic [15:0] phase_a_voltage_offset;
    logic [15:0] phase_b_voltage_offset;
    logic [15:0] phase_c_voltage_offset;
    logic [7:0]  phase_a_volt_temp_gain;
    logic [7:0]  phase_b_volt_temp_gain;
    logic [7:0]  phase_c_volt_temp_gain;
    logic [7:0]  freq_phase_term;
  } mcrb_cal_s;

endpackage

// ### mcrb_bank_checker.sv
// checker: port timing assertions for the calibration bank
`timescale 1ns/10ps
module mcrb_bank_checker (
  input logic                         aclk,
  input logic                         aresetn,
  input logic                         s_axi_awready,
  input logic                         s_axi_wready,
  input logic [1:0]                   s_axi_bresp,
  input logic                         s_axi_bvalid,
  input logic                         s_axi_bready,
  input logic                         s_axi_arvalid,
  input logic                         s_axi_arready,
  input logic [mcrb_pkg::DATA_W-1:0]  s_axi_rdata,
  input logic                         s_axi_rvalid,
  input logic                         s_axi_rready,
  input logic                         other_detect_wr,
  input mcrb_pkg::mcrb_detect_s       chan3_detect,
  input mcrb_pkg::mcrb_cal_s          cal
);
  // ****
  // assertions
  // ****
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  cal_hold_a: assert property ($changed(cal) |-> $rose(s_axi_bvalid))
    else $error("cal outputs moved without a write commit");
  latch_load_a: assert property (
    $changed(chan3_detect) |-> $rose(s_axi_bvalid) || $past(other_detect_wr))
    else $error("detector latch moved without a load");
  ready_low_a: assert property (
    $rose(s_axi_bvalid) |-> !s_axi_awready && !s_axi_wready)
    else $error("write channels open while response pending");
  read_lat_a: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read data not one cycle after address");
  rdata_hold_a: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before rready");
  bresp_hold_a: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before bready");
  rd_upper_a: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("upper read half not zero");
  b_release_a: assert property (
    s_axi_bvalid && s_axi_bready |=>
      !s_axi_bvalid && s_axi_awready && s_axi_wready)
    else $error("write channel not released after response");
  cover property ($rose(s_axi_bvalid));
  cover property (s_axi_rvalid && s_axi_rready);
  cover property (other_detect_wr);
endmodule

bind mcrb_bank mcrb_bank_checker i_chk (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .other_detect_wr(other_detect_wr), .chan3_detect(chan3_detect), .cal(cal));

// ### testbench.sv
// testbench: self-checking axi4-lite test of the calibration bank
`timescale 1ns/10ps
module testbench;
  logic                   aclk = 1'h0;
  logic                   aresetn = 1'h0;
  logic [7:0]             awaddr = 8'h00;
  logic [7:0]             araddr = 8'h00;
  logic [31:0]            wdata = 32'h0;
  logic [3:0]             wstrb = 4'h0;
  logic                   awvalid = 1'h0;
  logic                   wvalid = 1'h0;
  logic                   bready = 1'h0;
  logic                   arvalid = 1'h0;
  logic                   rready = 1'h0;
  logic                   other_wr = 1'h0;
  logic                   awready, wready, bvalid, arready, rvalid;
  logic [1:0]             bresp, rresp;
  logic [31:0]            rdata, r;
  mcrb_pkg::mcrb_detect_s det;
  mcrb_pkg::mcrb_cal_s    cal;
  logic [15:0]            m [64];
  logic [15:0]            m_det;
  logic [15:0]            codes [4] = '{16'h00FF, 16'hFF00, 16'h0000,
                                        16'hFFFF};
  logic [1:0]             bq [$];
  logic [33:0]            rq [$];
  int                     errors = 0;
  int                     samples_checked = 0;
  int                     seed = 91;

  always #20 aclk = ~aclk;

  mcrb_bank i_mcrb_bank (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .other_detect_wr(other_wr),
    .chan3_detect(det), .cal(cal));

  // ****
  // helpers
  // ****
  task automatic cmp(input logic [143:0] g, input logic [143:0] e,
                     input string s);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, s, g, e);
    end
  endtask

  function automatic bit mapped(input logic [5:0] i);
    return i >= mcrb_pkg::IDX_FIRST && i <= mcrb_pkg::IDX_LAST;
  endfunction

  task automatic do_reset();
    aresetn <= 1'h0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    for (int k = 0; k < 64; k++) m[k] = 16'h0000;
  endtask

  // bready starts random so a response sometimes waits on the master
  task automatic wr(input logic [7:0] a, input logic [15:0] d,
                    input logic [1:0] s);
    logic [5:0]  i;
    logic [15:0] v;
    bit          b;
    i = a[7:2];
    v = m[i];
    b = 1;
    r = $random(seed);
    awaddr <= a;
    wdata <= {r[31:16], d};
    wstrb <= {r[3:2], s};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= r[0];
    bq.push_back(mapped(i) ? mcrb_pkg::RESP_OKAY : mcrb_pkg::RESP_SLVERR);
    while (b) begin
      @(posedge aclk);
      awvalid <= awvalid & ~awready;
      wvalid <= wvalid & ~wready;
      b = !(bvalid && bready);
      bready <= b & (bready | bvalid);
    end
    @(posedge aclk);
    if (s[0]) v[7:0] = d[7:0];
    if (s[1]) v[15:8] = d[15:8];
    if (i > 6'h1A) v[15:8] = 8'h00;
    if (mapped(i)) m[i] = v;
    if (i == mcrb_pkg::IDX_CHAN3_DETECT_THRESHOLD) m_det = v;
  endtask

  task automatic rd(input logic [7:0] a);
    bit b;
    b = 1;
    r = $random(seed);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= r[1];
    rq.push_back(mapped(a[7:2]) ? {mcrb_pkg::RESP_OKAY, 16'h0000, m[a[7:2]]}
                                : {mcrb_pkg::RESP_SLVERR, 32'h0});
    while (b) begin
      @(posedge aclk);
      arvalid <= arvalid & ~arready;
      b = !(rvalid && rready);
      rready <= b & (rready | rvalid);
    end
    @(posedge aclk);
  endtask

  task automatic chk_cal();
    mcrb_pkg::mcrb_cal_s e;
    e = {m[6'h14], m[6'h15], m[6'h16], m[6'h17], m[6'h18], m[6'h19],
         m[6'h1A][7:0], m[6'h1A][15:8], m[6'h1B][7:0], m[6'h1C][7:0]};
    cmp(cal, e, "cal outputs");
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ****
  // response monitor
  // ****
  always @(posedge aclk) begin
    if (bvalid && bready) cmp(bresp, bq.pop_front(), "bresp");
    if (rvalid && rready)
      cmp({rresp, rdata}, rq.pop_front(), "read");
  end

  initial begin
    #2000000;
    errors++;
    end_of_test();
  end

  // ****
  // scenarios
  // ****
  initial begin
    do_reset();
    for (int k = 8'h48; k <= 8'h74; k += 4) rd(k[7:0]);
    chk_cal();
    $display("test reset values finished at %0t", $time);
    for (int k = 8'h4C; k <= 8'h74; k += 4) begin
      r = $random(seed);
      wr(k[7:0], r[15:0], 2'h3);
      rd(k[7:0]);
    end
    chk_cal();
    wr(8'h68, 16'hA55A, 2'h1);
    wr(8'h68, 16'h3CC3, 2'h2);
    wr(8'h6C, 16'hFFFF, 2'h3);
    wr(8'h70, 16'hFFFF, 2'h2);
    for (int k = 8'h68; k <= 8'h70; k += 4) rd(k[7:0]);
    chk_cal();
    $display("test field layout finished at %0t", $time);
    for (int k = 0; k < 4; k++) begin
      wr(8'h4C, codes[k], 2'h3);
      cmp(det, m_det, "detector codes");
    end
    wr(8'h4C, 16'h5A5A, 2'h1);
    cmp(det, m_det, "detector partial");
    wr(8'h4C, 16'hC35A, 2'h3);
    do_reset();
    cmp(det, 16'hC35A, "latch across reset");
    rd(8'h4C);
    chk_cal();
    other_wr <= 1'h1;
    @(posedge aclk);
    other_wr <= 1'h0;
    @(posedge aclk);
    cmp(det, 16'h0000, "sibling reload");
    $display("test detector latch finished at %0t", $time);
    end_of_test();
  end
endmodule
